/* File: rtl/lcag_pkg.sv */
/*
 * Constants, types and state list for the lifecycle access gate.
 * Assumes one synchronous clock domain and an active-low async reset.
 */
package lcag_pkg;

    typedef enum logic [3:0] {
        chip_manufacturing_state,
        secure_software_development_state,
        nonsecure_software_development_state,
        deployed_state,
        locked_debug_state,
        locked_boot_state,
        return_request_state,
        return_acknowledged_state
    } lcag_state_t;

    typedef enum logic [1:0] {
        no_debug_level,
        nonsecure_only_debug_level,
        full_debug_level
    } lcag_dbg_t;

    // Serial programming scope
    typedef struct packed {
        logic available;
        logic nonsec_flash;
        logic sec_flash;
    } lcag_scope_t;

    // Transition request from bootloader side
    typedef struct packed {
        logic        valid;
        logic        initialize;
        logic        authenticated;
        lcag_state_t target;
    } lcag_req_t;

    localparam lcag_state_t LCAG_RESET_STATE = chip_manufacturing_state;
    localparam logic [3:0]  LCAG_RANK_NONE   = 4'h0;

endpackage : lcag_pkg

/* File: rtl/lcag_policy.sv */
/*
 * Combinational map from lifecycle state to debug level and serial scope.
 * Assumes its state input is a registered value.
 */
`timescale 1ns/1ps
module lcag_policy (
    // State
    input  wire lcag_pkg::lcag_state_t state,
    // Grants
    output lcag_pkg::lcag_dbg_t        dbg_level,
    output lcag_pkg::lcag_scope_t      scope
);
    always_comb
    begin
        dbg_level = lcag_pkg::no_debug_level;
        scope     = '{available: 1'b1, nonsec_flash: 1'b0, sec_flash: 1'b0};
        case (state)
            lcag_pkg::chip_manufacturing_state:
                dbg_level = lcag_pkg::full_debug_level;
            lcag_pkg::secure_software_development_state:
            begin
                dbg_level = lcag_pkg::full_debug_level;
                scope     = '{1'b1, 1'b1, 1'b1};
            end
            lcag_pkg::nonsecure_software_development_state:
            begin
                dbg_level = lcag_pkg::nonsecure_only_debug_level;
                scope     = '{1'b1, 1'b1, 1'b0};
            end
            lcag_pkg::deployed_state:
                dbg_level = lcag_pkg::no_debug_level;
            lcag_pkg::locked_debug_state:
                dbg_level = lcag_pkg::no_debug_level;
            lcag_pkg::locked_boot_state:
                scope = '{1'b0, 1'b0, 1'b0};
            lcag_pkg::return_request_state:
                dbg_level = lcag_pkg::no_debug_level;
            lcag_pkg::return_acknowledged_state:
                dbg_level = lcag_pkg::full_debug_level;
            default:
                scope = '{1'b0, 1'b0, 1'b0};
        endcase
    end
endmodule : lcag_policy

/* File: rtl/lcag_gate.sv */
/*
 * Lifecycle access gate: holds the lifecycle state, applies transition
 * requests and gates debugger and serial-programming accesses.
 * Assumes all inputs synchronous to ref_clk; the flash erase engine
 * acknowledges the erase pulse elsewhere.
 */
`timescale 1ns/1ps
module lcag_gate (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    // Lifecycle transition requests
    input  wire lcag_pkg::lcag_req_t   trans_req,
    input  wire logic                  boot_mode,
    input  wire logic                  init_disabled,
    // Debugger access
    input  wire logic                  dbg_connect_req,
    input  wire logic                  dbg_acc_req,
    input  wire logic                  dbg_acc_secure,
    // Serial programming access
    input  wire logic                  sp_acc_req,
    input  wire logic                  sp_acc_flash,
    input  wire logic                  sp_acc_secure,
    // Status and grants
    output lcag_pkg::lcag_state_t      state,
    output lcag_pkg::lcag_dbg_t        dbg_level,
    output logic                       dbg_connect_ok,
    output logic                       dbg_acc_ok,
    output logic                       sp_acc_ok,
    output logic                       flash_erase_all,
    output logic                       trans_done
);
    lcag_pkg::lcag_state_t state_r;
    lcag_pkg::lcag_state_t state_nxt;
    lcag_pkg::lcag_dbg_t   lvl;
    lcag_pkg::lcag_scope_t scope;
    logic                  erase_r;
    logic                  erase_nxt;
    logic                  done_r;
    logic                  done_nxt;

    // Access ranking; a forward move must go to a lower, nonzero rank
    function automatic logic [3:0] rank(input lcag_pkg::lcag_state_t s);
        case (s)
            lcag_pkg::chip_manufacturing_state:             rank = 4'h7;
            lcag_pkg::secure_software_development_state:    rank = 4'h6;
            lcag_pkg::nonsecure_software_development_state: rank = 4'h5;
            lcag_pkg::deployed_state:                       rank = 4'h4;
            lcag_pkg::return_request_state:                 rank = 4'h3;
            lcag_pkg::locked_debug_state:                   rank = 4'h2;
            lcag_pkg::locked_boot_state:                    rank = 4'h1;
            default:
                rank = lcag_pkg::LCAG_RANK_NONE;
        endcase
    endfunction : rank

    lcag_policy u_policy (
        .state     (state_r),
        .dbg_level (lvl),
        .scope     (scope)
    );

    wire req_ok  = trans_req.valid && boot_mode && scope.available;
    wire do_init = req_ok && trans_req.initialize && !init_disabled;
    wire do_fwd  = req_ok && !trans_req.initialize &&
                   !trans_req.authenticated &&
                   (rank(trans_req.target) < rank(state_r)) &&
                   (rank(trans_req.target) != lcag_pkg::LCAG_RANK_NONE);
    wire do_auth = req_ok && !trans_req.initialize &&
                   trans_req.authenticated &&
                   state_r == lcag_pkg::nonsecure_software_development_state &&
                   trans_req.target ==
                   lcag_pkg::secure_software_development_state;

    always_comb
    begin
        state_nxt = state_r;
        erase_nxt = 1'b0;
        done_nxt  = 1'b0;
        if (do_init)
        begin
            state_nxt = lcag_pkg::secure_software_development_state;
            erase_nxt = 1'b1;
            done_nxt  = 1'b1;
        end
        else if (do_fwd || do_auth)
        begin
            state_nxt = trans_req.target;
            done_nxt  = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= lcag_pkg::LCAG_RESET_STATE;
            erase_r <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            erase_r <= erase_nxt;
            done_r  <= done_nxt;
        end
    end

    // Grants from the registered state only
    wire dbg_on = lvl != lcag_pkg::no_debug_level;
    wire dbg_ok_acc = dbg_on && (lvl == lcag_pkg::full_debug_level ||
                      !dbg_acc_secure);
    wire sp_ok  = boot_mode && scope.available && (!sp_acc_flash ||
                  (sp_acc_secure ? scope.sec_flash : scope.nonsec_flash));

    assign state           = state_r;
    assign dbg_level       = lvl;
    assign dbg_connect_ok  = dbg_connect_req && dbg_on;
    assign dbg_acc_ok      = dbg_acc_req && dbg_ok_acc;
    assign sp_acc_ok       = sp_acc_req && sp_ok;
    assign flash_erase_all = erase_r;
    assign trans_done      = done_r;

    // All checks run on the one clock, muted while in reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_no_dbg_refuse: assert property (
        lvl == lcag_pkg::no_debug_level |-> !dbg_connect_ok && !dbg_acc_ok)
        else $error("debugger accepted at no debug level");

    a_partial_nonsec: assert property (
        lvl == lcag_pkg::nonsecure_only_debug_level && dbg_acc_secure
        |-> !dbg_acc_ok)
        else $error("secure access at partial debug level");

    a_full_dbg_all: assert property (
        lvl == lcag_pkg::full_debug_level && dbg_acc_req |-> dbg_acc_ok)
        else $error("full debug access refused");

    a_boot_mode_only: assert property (
        !boot_mode |-> !sp_acc_ok)
        else $error("serial access outside boot mode");

    a_locked_boot: assert property (
        state_r == lcag_pkg::locked_boot_state |-> !sp_acc_ok &&
        !dbg_connect_ok)
        else $error("locked boot state leaked access");

    // Entry edge excluded: only the state already held must stay
    a_locked_stays: assert property (
        state_r == lcag_pkg::locked_boot_state
        |=> state_r == lcag_pkg::locked_boot_state)
        else $error("locked boot state was left");

    a_init_erase: assert property (
        do_init |=> flash_erase_all &&
        state_r == lcag_pkg::secure_software_development_state)
        else $error("initialize did not erase and reset state");

    a_fwd_lower: assert property (
        $changed(state_r) && !$past(do_init) && !$past(do_auth)
        |-> rank(state_r) < rank($past(state_r)))
        else $error("forward move gained access");

    a_auth_no_erase: assert property (
        do_auth |=> !flash_erase_all &&
        state_r == lcag_pkg::secure_software_development_state)
        else $error("authenticated regression wrong");

    a_flash_scope: assert property (
        state_r == lcag_pkg::deployed_state && sp_acc_flash |-> !sp_acc_ok)
        else $error("flash reached in deployed state");

    a_cm_policy: assert property (
        state_r == lcag_pkg::chip_manufacturing_state
        |-> lvl == lcag_pkg::full_debug_level && scope.available &&
        !scope.nonsec_flash && !scope.sec_flash)
        else $error("manufacturing state grants wrong");

    a_ssd_policy: assert property (
        state_r == lcag_pkg::secure_software_development_state
        |-> lvl == lcag_pkg::full_debug_level && scope.available &&
        scope.nonsec_flash && scope.sec_flash)
        else $error("secure development grants wrong");

    a_nsd_policy: assert property (
        state_r == lcag_pkg::nonsecure_software_development_state
        |-> lvl == lcag_pkg::nonsecure_only_debug_level &&
        scope.available && scope.nonsec_flash && !scope.sec_flash)
        else $error("non-secure development grants wrong");

    a_locked_debug_state_policy: assert property (
        state_r == lcag_pkg::locked_debug_state
        |-> lvl == lcag_pkg::no_debug_level && scope.available &&
        !scope.nonsec_flash && !scope.sec_flash)
        else $error("locked debug state grants wrong");

    a_return_request_state_policy: assert property (
        state_r == lcag_pkg::return_request_state
        |-> lvl == lcag_pkg::no_debug_level && scope.available &&
        !scope.nonsec_flash && !scope.sec_flash)
        else $error("return request state grants wrong");

    a_return_acknowledged_state_policy: assert property (
        state_r == lcag_pkg::return_acknowledged_state
        |-> lvl == lcag_pkg::full_debug_level && scope.available &&
        !scope.nonsec_flash && !scope.sec_flash)
        else $error("return acknowledged state grants wrong");

    // Refused requests leave the stored phase alone
    a_state_held: assert property (
        !(do_init || do_fwd || do_auth)
        |=> !trans_done && state_r == $past(state_r))
        else $error("state moved without accepted request");

    a_done_pulse: assert property (
        do_init || do_fwd || do_auth |=> trans_done)
        else $error("accepted transition not reported");

    // Grant in the same cycle as the request
    a_grant_now: assert property (
        sp_acc_req && boot_mode && scope.available && !sp_acc_flash
        |-> sp_acc_ok)
        else $error("serial access not granted at once");
endmodule : lcag_gate

/* File: tb/lcag_host_model.sv */
/*
 * Host model: debugger and serial programming tool at the gate's far side.
 * Assumes the bench calls put shortly after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
module lcag_host_model (
    // Transition request and mode levels
    output lcag_pkg::lcag_req_t trans_req,
    output logic                boot_mode,
    output logic                init_disabled,
    // Access requests: connect, dbg req, dbg sec, sp req, flash, sec
    output logic [5:0]          acc
);
    // Debugger keeps connect up while it accesses
    task automatic put(input lcag_pkg::lcag_req_t r, input logic [7:0] m);
        trans_req = r;
        boot_mode = m[7];
        init_disabled = m[6];
        acc = {m[5] | m[4], m[4:0]};
    endtask : put

endmodule : lcag_host_model

/* File: tb/lifecycle_access_gate_tb.sv */
/*
 * Self-checking bench for the lifecycle access gate, directed and random.
 * Assumes lcag_gate answers transitions in the cycle right after the taking edge.
 */
`timescale 1ns/1ps
module lifecycle_access_gate_tb;
    // Per-state tables, index is the state code
    localparam logic [31:0] RK = 32'h0312_4567;
    localparam logic [15:0] LV = 16'h801a;
    localparam logic [7:0]  AV = 8'hdf;
    localparam logic [7:0]  NF = 8'h06;
    localparam logic [7:0]  SF = 8'h02;
    logic                  ref_clk = 1'b0;
    logic                  reset_n = 1'b0;
    lcag_pkg::lcag_req_t   trans_req;
    logic                  boot_mode;
    logic                  init_disabled;
    logic [5:0]            acc;
    lcag_pkg::lcag_state_t state;
    lcag_pkg::lcag_state_t exp_st;
    lcag_pkg::lcag_dbg_t   dbg_level;
    logic                  dbg_connect_ok;
    logic                  dbg_acc_ok;
    logic                  sp_acc_ok;
    logic                  flash_erase_all;
    logic                  trans_done;
    logic [1:0]            exp_p;
    int                    bad_count = 0;
    int                    total_checks = 0;
    logic [31:0]           seed = 32'h0000_aef9;

    always #25 ref_clk = ~ref_clk;

    lcag_host_model host (.trans_req(trans_req), .boot_mode(boot_mode),
        .init_disabled(init_disabled), .acc(acc));
    lcag_gate uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .trans_req(trans_req), .boot_mode(boot_mode),
        .init_disabled(init_disabled), .dbg_connect_req(acc[5]),
        .dbg_acc_req(acc[4]), .dbg_acc_secure(acc[3]),
        .sp_acc_req(acc[2]), .sp_acc_flash(acc[1]), .sp_acc_secure(acc[0]),
        .state(state), .dbg_level(dbg_level),
        .dbg_connect_ok(dbg_connect_ok), .dbg_acc_ok(dbg_acc_ok),
        .sp_acc_ok(sp_acc_ok), .flash_erase_all(flash_erase_all),
        .trans_done(trans_done));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic lcag_pkg::lcag_req_t rq(logic [2:0] t, logic v,
                                               logic i, logic a);
        return '{v, i, a & ~i, lcag_pkg::lcag_state_t'({1'b0, t})};
    endfunction : rq

    task automatic chk(string n, logic [3:0] e, logic [3:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic rst();
        host.put('0, 8'h80);
        reset_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        exp_st = lcag_pkg::chip_manufacturing_state;
        exp_p = 2'b00;
    endtask : rst

    // One cycle: drive, check settled outputs, predict next state
    task automatic cyc(lcag_pkg::lcag_req_t r, logic [7:0] m);
        logic [1:0] l;
        logic       ok;
        logic [3:0] rt;
        logic [3:0] rs;
        @(posedge ref_clk);
        #1;
        if (r.initialize)
            r.target = exp_st;
        host.put(r, m);
        #40;
        l = LV[exp_st*2 +: 2];
        rt = RK[r.target*4 +: 4];
        rs = RK[exp_st*4 +: 4];
        chk("state", exp_st, state);
        chk("level", l, dbg_level);
        chk("pulses", exp_p, {trans_done, flash_erase_all});
        chk("dbg_conn", acc[5] && l != 0, dbg_connect_ok);
        chk("dbg_acc", acc[4] && (l[1] || l[0] && !acc[3]),
            dbg_acc_ok);
        chk("sp_acc", acc[2] && boot_mode && AV[exp_st] && (!acc[1] ||
            (acc[0] ? SF[exp_st] : NF[exp_st])), sp_acc_ok);
        ok = r.valid && boot_mode && exp_st != lcag_pkg::locked_boot_state;
        if (r.initialize)
            ok &= !init_disabled;
        else if (r.authenticated)
            ok &= exp_st == 4'd2 && r.target == 4'd1;
        else
            ok &= rt < rs && rt != 0;
        exp_p = {ok, ok & r.initialize};
        if (ok)
            exp_st = r.initialize ?
                lcag_pkg::secure_software_development_state : r.target;
    endtask : cyc

    initial
    begin
        #500000;
        bad_count++;
        test_done();
    end

    initial
    begin
        rst();
        cyc(rq(3'd0, 1, 1, 0), 8'hbf);
        cyc(rq(3'd2, 1, 0, 0), 8'hbd);
        cyc(rq(3'd1, 1, 0, 1), 8'hbe);
        cyc(rq(3'd0, 1, 0, 0), 8'hb7);
        cyc(rq(3'd3, 1, 0, 0), 8'h3f);
        cyc(rq(3'd5, 1, 0, 0), 8'hbf);
        cyc(rq(3'd0, 1, 1, 0), 8'hbf);
        cyc(rq(3'd0, 0, 0, 0), 8'hbf);
        rst();
        cyc(rq(3'd0, 1, 1, 0), 8'hc0);
        for (int n = 0; n < 2000; n++)
        begin
            if (n % 150 == 149)
                rst();
            seed = xs();
            cyc(rq(seed[2:0], |seed[4:3], &seed[7:5], seed[8]),
                {|seed[11:9], &seed[13:12], seed[21:16]});
        end
        cyc(rq(3'd0, 0, 0, 0), 8'h80);
        test_done();
    end
endmodule : lifecycle_access_gate_tb
